// ---- bench/sdram_props.sv ----
// checker for the pin bundle between controller and device.
// assumes one clock; watches both ends at once.
`timescale 1ns/100ps
`default_nettype none
module sdram_props
  import sdram_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic csN,
  input wire logic rasN,
  input wire logic casN,
  input wire logic weN,
  input wire logic [BANK_W-1:0] bankSelect,
  input wire logic [ROW_W-1:0] muxAddress,
  input wire logic dqm,
  input wire logic cke,
  input wire logic ctrlOe,
  input wire logic devOe
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  logic [2:0] cmd;
  logic go;
  logic isRd;
  logic [2:0] clReg;
  logic [2:0] blReg;
  logic [NUM_BANKS-1:0] openReg;
  assign cmd = {rasN, casN, weN};
  assign go = cke && !csN;
  assign isRd = go && cmd == CMD_READ;
  //////////////////////////////
  // mode and open banks shadowed, so latency checks need no hierarchy
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      clReg <= CL_2;
      blReg <= BL_1;
      openReg <= '0;
    end else if (go) begin
      if (cmd == CMD_MRS) begin
        clReg <= muxAddress[6:4];
        blReg <= muxAddress[2:0];
      end
      if (cmd == CMD_ACT) openReg[bankSelect] <= 1'b1;
      if (cmd == CMD_PRE) openReg <= muxAddress[10] ? '0 : openReg & ~(4'h1 << bankSelect);
    end
  end
  //////////////////////////////
  property p_read_cl2;
    isRd && !dqm && openReg[bankSelect] && clReg == CL_2 |-> ##1 !devOe ##1 devOe;
  endproperty
  a_read_cl2: assert property (p_read_cl2) else $error("read data off latency two");
  property p_read_cl3;
    isRd && !dqm && openReg[bankSelect] && clReg == CL_3 |-> ##2 !devOe ##1 devOe;
  endproperty
  a_read_cl3: assert property (p_read_cl3) else $error("read data off latency three");
  property p_first_beat;
    $rose(devOe) |-> (clReg == CL_2) ? $past(isRd, 2) : $past(isRd, 3);
  endproperty
  a_first_beat: assert property (p_first_beat) else $error("data without a read");
  property p_dqm_float;
    dqm |-> ##2 !devOe;
  endproperty
  a_dqm_float: assert property (p_dqm_float) else $error("masked read beat driven");
  property p_burst4;
    $rose(devOe) && blReg == BL_4 |-> devOe [*4] ##1 !devOe;
  endproperty
  a_burst4: assert property (p_burst4) else $error("burst of four wrong length");
  property p_burst1;
    $rose(devOe) && blReg == BL_1 |=> !devOe;
  endproperty
  a_burst1: assert property (p_burst1) else $error("single burst too long");
  property p_bus_owner;
    !(ctrlOe && devOe);
  endproperty
  a_bus_owner: assert property (p_bus_owner) else $error("both ends drive data");
  property p_write_data;
    go && cmd == CMD_WRITE |-> ctrlOe ##1 !ctrlOe;
  endproperty
  a_write_data: assert property (p_write_data) else $error("write byte not with command");
  property p_pulse;
    !csN && cmd != CMD_NOP |=> csN || cmd == CMD_NOP;
  endproperty
  a_pulse: assert property (p_pulse) else $error("command held over one cycle");
  property p_act_gap;
    go && cmd == CMD_ACT |=> (csN || cmd == CMD_NOP) [*4];
  endproperty
  a_act_gap: assert property (p_act_gap) else $error("command too soon after activate");
  property p_pre_gap;
    go && cmd == CMD_PRE |=> (csN || cmd == CMD_NOP) [*4];
  endproperty
  a_pre_gap: assert property (p_pre_gap) else $error("command too soon after precharge");
  property p_mrs_gap;
    go && cmd == CMD_MRS |=> (csN || cmd == CMD_NOP) [*3];
  endproperty
  a_mrs_gap: assert property (p_mrs_gap) else $error("command too soon after mode set");
  c_masked_read: cover property (isRd && dqm);
  c_burst4: cover property ($rose(devOe) && blReg == BL_4);
  c_cl3: cover property (isRd && clReg == CL_3);
endmodule
`default_nettype wire

// ---- bench/testbench.sv ----
// self-checking bench: controller and device joined by the pin bundle.
// assumes the zero-wait ahb slave and the controller's register map.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import sdram_pkg::*;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = '0;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic powerDown;
  logic selfRefresh;
  logic [31:0] rd;
  logic [7:0] beats[$];
  int error_cnt = 0;
  int checks_done = 0;
  int cycles = 0;
  always #2 clk_sys = ~clk_sys;
  //////////////////////////////
  sdram_if u_sdram_if();
  sdram_controller u_sdram_controller(.clk_sys(clk_sys), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pins(u_sdram_if.controller));
  sdram_device u_sdram_device(.clk_sys(clk_sys), .sys_rst(sys_rst), .mem(u_sdram_if.memory),
    .powerDown(powerDown), .selfRefresh(selfRefresh));
  sdram_props u_sdram_props(.clk_sys(clk_sys), .sys_rst(sys_rst), .csN(u_sdram_if.csN),
    .rasN(u_sdram_if.rasN), .casN(u_sdram_if.casN), .weN(u_sdram_if.weN),
    .bankSelect(u_sdram_if.bankSelect), .muxAddress(u_sdram_if.muxAddress), .dqm(u_sdram_if.dqm),
    .cke(u_sdram_if.cke), .ctrlOe(u_sdram_if.ctrlOe), .devOe(u_sdram_if.devOe));
  //////////////////////////////
  // beats collected off the wire, since the controller keeps only the first
  always @(posedge clk_sys) begin
    if (u_sdram_if.devOe === 1'b1) beats.push_back(u_sdram_if.devDq);
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      error_cnt++;
      test_done();
    end
  end
  task automatic test_done();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  // busy polled: a command written while busy would be dropped
  task automatic op(input logic [2:0] c, input logic [1:0] b, input logic [11:0] a, input logic m);
    ahb(1'b1, REG_CMD, {11'h0, m, a, 2'h0, b, 1'b0, c});
    for (int i = 0; i < 40; i++) begin
      ahb(1'b0, REG_STATUS, 32'h0);
      if (rd[ST_BUSY_BIT] === 1'b0) break;
    end
  endtask
  task automatic wrb(input logic [1:0] b, input logic [9:0] col, input logic [7:0] d, input logic m);
    ahb(1'b1, REG_WDATA, {24'h0, d});
    op(CMD_WRITE, b, {2'h0, col}, m);
  endtask
  task automatic rdchk(input logic [1:0] b, input logic [9:0] col, input logic m, input logic [7:0] e);
    op(CMD_READ, b, {2'h0, col}, m);
    ahb(1'b0, REG_RDATA, 32'h0);
    cmp("rdata", {24'h0, e}, rd);
  endtask
  // single-write mode so bursts only read; refresh off to keep timing fixed
  task automatic mode(input logic [2:0] bl, input logic il, input logic [2:0] cl);
    op(CMD_PRE, 2'h0, 12'h400, 1'b0);
    op(CMD_MRS, 2'h0, {2'h0, 1'b1, 2'h0, cl, il, bl}, 1'b0);
    ahb(1'b1, REG_CTRL, {25'h0, cl, 4'h1});
    op(CMD_ACT, 2'h1, 12'h5A5, 1'b0);
    op(CMD_ACT, 2'h2, 12'h0C3, 1'b0);
  endtask
  task automatic burst(input logic il);
    mode(BL_4, il, CL_2);
    beats.delete();
    rdchk(2'h1, 10'h011, 1'b0, 8'h11);
    cmp("beats", 32'h4, 32'(beats.size()));
    for (int i = 0; i < 4; i++) begin
      cmp("beat", 32'(8'h10 + (il ? (1 ^ i) : ((1 + i) % 4))), {24'h0, beats[i]});
    end
  endtask
  //////////////////////////////
  initial begin
    repeat (5) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    ahb(1'b0, REG_CTRL, 32'h0);
    cmp("ctrl reset", CTRL_RESET, rd);
    ahb(1'b0, 8'h20, 32'h0);
    cmp("unmapped", 32'h0, rd);
    mode(BL_1, 1'b0, CL_2);
    for (int i = 0; i < 4; i++) begin
      wrb(2'h1, 10'(16 + i), 8'(16 + i), 1'b0);
    end
    wrb(2'h2, 10'h011, 8'hA7, 1'b0);
    wrb(2'h1, 10'h011, 8'hFF, 1'b1);
    rdchk(2'h1, 10'h011, 1'b0, 8'h11);
    rdchk(2'h2, 10'h011, 1'b0, 8'hA7);
    rdchk(2'h3, 10'h011, 1'b0, 8'h00);
    rdchk(2'h1, 10'h012, 1'b1, 8'h00);
    burst(1'b0);
    burst(1'b1);
    mode(BL_1, 1'b0, CL_3);
    rdchk(2'h1, 10'h013, 1'b0, 8'h13);
    rdchk(2'h1, 10'h010, 1'b1, 8'h10);
    ahb(1'b1, REG_CTRL, 32'h00000030);
    repeat (3) @(posedge clk_sys);
    cmp("power down", 32'h1, {31'h0, powerDown});
    cmp("no self refresh", 32'h0, {31'h0, selfRefresh});
    ahb(1'b1, REG_CTRL, 32'h00000031);
    repeat (3) @(posedge clk_sys);
    cmp("power up", 32'h0, {31'h0, powerDown});
    cmp("self refresh off", 32'h0, {31'h0, selfRefresh});
    rdchk(2'h2, 10'h011, 1'b0, 8'hA7);
    cmp("hresp", 32'h0, {31'h0, hresp});
    test_done();
  end
endmodule
`default_nettype wire

// ---- logic/burst_column.sv ----
// column generator for one beat of a burst.
// assumes the caller holds start column and beat index stable for the cycle.
`timescale 1ns/100ps
`default_nettype none
module burst_column
  import sdram_pkg::*;
(
  input wire logic [COL_W-1:0] startCol,
  input wire logic [COL_W-1:0] beatIdx,
  input wire logic [2:0] burstCode,
  input wire logic interleaved,
  output logic [COL_W-1:0] column
);

  logic [COL_W-1:0] mask;
  logic [COL_W-1:0] seqCol;

  always_comb begin
    mask = burstMask(burstCode);
    seqCol = COL_W'(startCol + beatIdx);
    if (burstCode == BL_FULL) begin
      column = seqCol;
    end else if (interleaved) begin
      column = (startCol & ~mask) | ((startCol ^ beatIdx) & mask);
    end else begin
      column = (startCol & ~mask) | (seqCol & mask);
    end
  end

endmodule
`default_nettype wire

// ---- logic/sdram_controller.sv ----
// memory controller end: takes single commands from software over ahb-lite,
// spaces them by the minimum gaps and keeps the refresh budget.
// assumes software opens rows and precharges banks before refresh.
`timescale 1ns/100ps
`default_nettype none
module sdram_controller
  import sdram_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  sdram_if.controller pins
);

  typedef struct packed {
    ctl_state_t state;
    logic [7:0] waitCnt;
    logic [2:0] capCnt;
    logic [11:0] refCnt;
    logic refPend;
    logic [31:0] ctrlReg;
    logic [DQ_W-1:0] wdata;
    logic [DQ_W-1:0] rdata;
    logic rdValid;
    logic cmdPend;
    logic [31:0] cmdReg;
    logic dphWrite;
    logic [7:0] dphAddr;
    logic [31:0] rdWord;
    logic csN;
    logic [2:0] cmdPins;
    logic [BANK_W-1:0] bank;
    logic [ROW_W-1:0] addr;
    logic dqm;
    logic [DQ_W-1:0] dq;
    logic dqOe;
  } ctl_t;

  localparam ctl_t CTL_RESET = '{state: CS_IDLE, ctrlReg: CTRL_RESET, csN: 1'b1, cmdPins: CMD_NOP, default: '0};

  ctl_t r_reg;
  ctl_t r_next;

  logic ahbSel;
  logic refTick;
  logic refIssue;
  logic captured;
  logic rdClear;
  logic [2:0] op;
  logic [2:0] casLat;

  // cycles to hold off after a command
  function automatic logic [7:0] gapFor(input logic [2:0] code, input logic [2:0] cl);
    case (code)
      CMD_ACT: gapFor = 8'(T_RCD_CYC > T_RRD_CYC ? T_RCD_CYC : T_RRD_CYC);
      CMD_PRE: gapFor = 8'(T_RP_CYC);
      CMD_MRS: gapFor = 8'(T_RSC_CYC);
      CMD_REF: gapFor = 8'(T_RC_CYC);
      CMD_READ: gapFor = 8'({5'h00, cl} + 8'h02);
      default: gapFor = 8'h01;
    endcase
  endfunction

  always_comb begin
    r_next = r_reg;
    ahbSel = hsel && htrans[1] && hready;
    casLat = r_reg.ctrlReg[CTRL_CL_LSB +: 3];
    op = r_reg.cmdReg[CMD_OP_LSB +: 3];
    refIssue = 1'b0;
    rdClear = 1'b0;
    captured = 1'b0;
    // pins return to no-operation after one cycle
    r_next.csN = 1'b1;
    r_next.cmdPins = CMD_NOP;
    r_next.dqOe = 1'b0;
    r_next.dqm = 1'b0;
    // refresh budget: one row every interval
    refTick = (r_reg.refCnt == 12'(REF_INTERVAL_CYC - 1));
    r_next.refCnt = refTick ? 12'h000 : 12'(r_reg.refCnt + 1'b1);
    if (r_reg.capCnt != 3'h0) begin
      r_next.capCnt = 3'(r_reg.capCnt - 1'b1);
      if (r_reg.capCnt == 3'h1) begin
        r_next.rdata = pins.dataBus;
        captured = 1'b1;
      end
    end
    if (r_reg.dphWrite) begin
      case (r_reg.dphAddr)
        REG_CMD: begin
          // a command written while busy is dropped
          if ((r_reg.state == CS_IDLE) && !r_reg.cmdPend) begin
            r_next.cmdPend = 1'b1;
            r_next.cmdReg = hwdata;
          end
        end
        REG_WDATA: r_next.wdata = hwdata[DQ_W-1:0];
        REG_CTRL: r_next.ctrlReg = hwdata;
        default: r_next.dphWrite = 1'b0;
      endcase
    end
    r_next.dphWrite = ahbSel && hwrite;
    r_next.dphAddr = haddr[7:0];
    if (ahbSel && !hwrite) begin
      case (haddr[7:0])
        REG_CMD: r_next.rdWord = r_reg.cmdReg;
        REG_WDATA: r_next.rdWord = {24'h000000, r_reg.wdata};
        REG_STATUS: r_next.rdWord = {29'h00000000, r_reg.refPend, r_reg.rdValid,
                                     (r_reg.state != CS_IDLE) || r_reg.cmdPend};
        REG_RDATA: begin
          r_next.rdWord = {24'h000000, r_reg.rdata};
          rdClear = 1'b1;
        end
        REG_CTRL: r_next.rdWord = r_reg.ctrlReg;
        default: r_next.rdWord = 32'h00000000;
      endcase
    end
    case (r_reg.state)
      CS_IDLE: begin
        if (r_reg.refPend && r_reg.ctrlReg[CTRL_AREF_BIT]) begin
          refIssue = 1'b1;
          r_next.csN = 1'b0;
          r_next.cmdPins = CMD_REF;
          r_next.waitCnt = gapFor(CMD_REF, casLat);
          r_next.state = CS_WAIT;
        end else if (r_reg.cmdPend) begin
          r_next.cmdPend = 1'b0;
          r_next.csN = 1'b0;
          r_next.cmdPins = op;
          r_next.bank = r_reg.cmdReg[CMD_BANK_LSB +: BANK_W];
          r_next.addr = r_reg.cmdReg[CMD_ADDR_LSB +: ROW_W];
          r_next.dqm = r_reg.cmdReg[CMD_DQM_BIT];
          r_next.waitCnt = gapFor(op, casLat);
          if (op == CMD_WRITE) begin
            r_next.dqOe = 1'b1;
            r_next.dq = r_reg.wdata;
          end
          if (op == CMD_READ) begin
            r_next.capCnt = 3'(casLat + 1'b1);
          end
          r_next.state = CS_WAIT;
        end
      end
      CS_WAIT: begin
        if (r_reg.waitCnt <= 8'h01) begin
          r_next.state = CS_IDLE;
        end else begin
          r_next.waitCnt = 8'(r_reg.waitCnt - 1'b1);
        end
      end
      default: r_next.state = CS_IDLE;
    endcase
    // a new event wins over the clear in the same cycle
    r_next.rdValid = captured || (r_reg.rdValid && !rdClear);
    r_next.refPend = refTick || (r_reg.refPend && !refIssue);
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      r_reg <= CTL_RESET;
    end else begin
      r_reg <= r_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = r_reg.rdWord;
  assign pins.csN = r_reg.csN;
  assign pins.rasN = r_reg.cmdPins[2];
  assign pins.casN = r_reg.cmdPins[1];
  assign pins.weN = r_reg.cmdPins[0];
  assign pins.bankSelect = r_reg.bank;
  assign pins.muxAddress = r_reg.addr;
  assign pins.dqm = r_reg.dqm;
  assign pins.cke = r_reg.ctrlReg[CTRL_CKE_BIT];
  assign pins.ctrlDq = r_reg.dq;
  assign pins.ctrlOe = r_reg.dqOe;

endmodule
`default_nettype wire

// ---- logic/sdram_device.sv ----
// four-bank byte-wide synchronous dram, seen from its pins.
// assumes the controller keeps bank timing and refresh budget; no reset pin
// exists on the real part, sys_rst only puts the model into a known state.
`timescale 1ns/100ps
`default_nettype none

module sdram_device
  import sdram_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  sdram_if.memory mem,
  output logic powerDown,
  output logic selfRefresh
);

  localparam int MEM_DEPTH = 1 << (BANK_W + ROW_W + COL_W);

  typedef struct packed {
    dev_state_t state;
    logic [NUM_BANKS-1:0] bankOpen;
    logic [NUM_BANKS-1:0][ROW_W-1:0] openRow;
    logic [2:0] burstCode;
    logic interleaved;
    logic [2:0] casLat;
    logic singleWrite;
    logic burstOn;
    logic burstWrite;
    logic [BANK_W-1:0] burstBank;
    logic [COL_W-1:0] startCol;
    logic [COL_W-1:0] beatIdx;
    logic [2:0] rdValid;
    logic [2:0][DQ_W-1:0] rdData;
    logic [1:0] dqmPipe;
  } dev_t;

  localparam dev_t DEV_RESET = '{state: ST_RUN, casLat: CL_2, burstCode: BL_1, default: '0};

  dev_t r_reg;
  dev_t r_next;

  // one byte per column location in every bank
  logic [DQ_W-1:0] cells [0:MEM_DEPTH-1];

  logic clockOn;
  logic decodeOn;
  logic [2:0] cmd;
  logic newColCmd;
  logic accOn;
  logic accWrite;
  logic [BANK_W-1:0] accBank;
  logic [COL_W-1:0] startSel;
  logic [COL_W-1:0] idxSel;
  logic [COL_W-1:0] column;
  logic lastBeat;
  logic memWe;
  logic [BANK_W+ROW_W+COL_W-1:0] memAddr;
  logic [DQ_W-1:0] readByte;

  ////////////////////////////////////////////////////////////////////////////
  // burst column counter

  burst_column colGen (
    .startCol(startSel),
    .beatIdx(idxSel),
    .burstCode(r_reg.burstCode),
    .interleaved(r_reg.interleaved),
    .column(column)
  );

  ////////////////////////////////////////////////////////////////////////////
  // access decode

  always_comb begin
    clockOn = mem.cke && (r_reg.state == ST_RUN);
    decodeOn = clockOn && !mem.csN;
    cmd = {mem.rasN, mem.casN, mem.weN};
    // a column command only counts in an opened bank
    newColCmd = decodeOn && ((cmd == CMD_READ) || (cmd == CMD_WRITE))
                && r_reg.bankOpen[mem.bankSelect];
    accBank = newColCmd ? mem.bankSelect : r_reg.burstBank;
    startSel = newColCmd ? mem.muxAddress[COL_W-1:0] : r_reg.startCol;
    idxSel = newColCmd ? '0 : r_reg.beatIdx;
    accWrite = newColCmd ? (cmd == CMD_WRITE) : r_reg.burstWrite;
    accOn = clockOn && (newColCmd || r_reg.burstOn);
    lastBeat = ((r_reg.burstCode != BL_FULL) && (idxSel == burstMask(r_reg.burstCode)))
               || (accWrite && r_reg.singleWrite);
    memAddr = {accBank, r_reg.openRow[accBank], column};
    memWe = accOn && accWrite && !mem.dqm;
  end

  assign readByte = cells[memAddr];

  always_ff @(posedge clk_sys) begin
    if (memWe) begin
      cells[memAddr] <= mem.dataBus;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    r_next = r_reg;
    if (clockOn) begin
      // latency pipes only advance while the internal clock runs
      r_next.rdValid = {r_reg.rdValid[1:0], accOn && !accWrite};
      r_next.rdData = {r_reg.rdData[1:0], readByte};
      r_next.dqmPipe = {r_reg.dqmPipe[0], mem.dqm};
      if (accOn) begin
        r_next.burstOn = !lastBeat;
        r_next.burstWrite = accWrite;
        r_next.burstBank = accBank;
        r_next.startCol = startSel;
        r_next.beatIdx = COL_W'(idxSel + 1'b1);
      end
      if (decodeOn) begin
        case (cmd)
          CMD_ACT: begin
            r_next.bankOpen[mem.bankSelect] = 1'b1;
            r_next.openRow[mem.bankSelect] = mem.muxAddress;
          end
          CMD_PRE: begin
            if (mem.muxAddress[PRECHARGE_ALL_BIT]) begin
              r_next.bankOpen = '0;
              r_next.burstOn = 1'b0;
            end else begin
              r_next.bankOpen[mem.bankSelect] = 1'b0;
              if (mem.bankSelect == r_reg.burstBank) begin
                r_next.burstOn = 1'b0;
              end
            end
          end
          CMD_MRS: begin
            r_next.burstCode = mem.muxAddress[MODE_BL_LSB +: 3];
            r_next.interleaved = mem.muxAddress[MODE_BT_BIT];
            r_next.singleWrite = mem.muxAddress[MODE_WBM_BIT];
            // only the two supported latencies are taken
            if ((mem.muxAddress[MODE_CL_LSB +: 3] == CL_2) || (mem.muxAddress[MODE_CL_LSB +: 3] == CL_3)) begin
              r_next.casLat = mem.muxAddress[MODE_CL_LSB +: 3];
            end
            r_next.burstOn = 1'b0;
          end
          CMD_STOP: begin
            r_next.burstOn = 1'b0;
          end
          default: begin
            r_next.burstOn = r_next.burstOn;
          end
        endcase
      end
    end
    case (r_reg.state)
      ST_RUN: begin
        if (!mem.cke) begin
          // refresh with clock enable low enters self refresh, idle enters
          // power down, an open burst is suspended in place
          if (!mem.csN && (cmd == CMD_REF)) begin
            r_next.state = ST_SREF;
          end else if (!r_reg.burstOn) begin
            r_next.state = ST_PDOWN;
          end
        end
      end
      ST_PDOWN, ST_SREF: begin
        if (mem.cke) begin
          r_next.state = ST_RUN;
        end
      end
      default: begin
        r_next.state = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      r_reg <= DEV_RESET;
    end else begin
      r_reg <= r_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  always_comb begin
    // stage 1 feeds latency two, stage 2 latency three
    if (r_reg.casLat == CL_3) begin
      mem.devDq = r_reg.rdData[2];
      mem.devOe = r_reg.rdValid[2] && !r_reg.dqmPipe[1];
    end else begin
      mem.devDq = r_reg.rdData[1];
      mem.devOe = r_reg.rdValid[1] && !r_reg.dqmPipe[1];
    end
  end

  assign powerDown = (r_reg.state == ST_PDOWN);
  assign selfRefresh = (r_reg.state == ST_SREF);

endmodule
`default_nettype wire

// ---- logic/sdram_if.sv ----
// pin bundle between memory controller and memory device.
// both ends run on the same clk_sys; the shared data pins are resolved here.
`timescale 1ns/100ps
`default_nettype none
interface sdram_if;
  import sdram_pkg::*;
  logic csN;
  logic rasN;
  logic casN;
  logic weN;
  logic [BANK_W-1:0] bankSelect;
  logic [ROW_W-1:0] muxAddress;
  logic dqm;
  logic cke;
  logic [DQ_W-1:0] ctrlDq;
  logic ctrlOe;
  logic [DQ_W-1:0] devDq;
  logic devOe;
  logic [DQ_W-1:0] dataBus;

  // undriven bus reads as zero
  assign dataBus = ctrlOe ? ctrlDq : (devOe ? devDq : '0);

  modport memory(input csN, rasN, casN, weN, bankSelect, muxAddress, dqm, cke, dataBus,
                 output devDq, devOe);
  modport controller(output csN, rasN, casN, weN, bankSelect, muxAddress, dqm, cke, ctrlDq, ctrlOe,
                     input dataBus);
endinterface
`default_nettype wire

// ---- logic/sdram_pkg.sv ----
// shared constants, command codes and helpers for the sdram link.
// assumes a single 250 MHz clock shared by both ends.
package sdram_pkg;

  localparam int ROW_W = 12;
  localparam int COL_W = 10;
  localparam int BANK_W = 2;
  localparam int DQ_W = 8;
  localparam int NUM_BANKS = 4;

  // strobe codes {row, column, write}, all active low
  localparam logic [2:0] CMD_MRS = 3'h0;
  localparam logic [2:0] CMD_REF = 3'h1;
  localparam logic [2:0] CMD_PRE = 3'h2;
  localparam logic [2:0] CMD_ACT = 3'h3;
  localparam logic [2:0] CMD_WRITE = 3'h4;
  localparam logic [2:0] CMD_READ = 3'h5;
  localparam logic [2:0] CMD_STOP = 3'h6;
  localparam logic [2:0] CMD_NOP = 3'h7;

  // mode word on the address pins
  localparam int MODE_BL_LSB = 0;
  localparam int MODE_BT_BIT = 3;
  localparam int MODE_CL_LSB = 4;
  localparam int MODE_WBM_BIT = 9;
  localparam int PRECHARGE_ALL_BIT = 10;
  localparam logic [2:0] BL_1 = 3'h0;
  localparam logic [2:0] BL_2 = 3'h1;
  localparam logic [2:0] BL_4 = 3'h2;
  localparam logic [2:0] BL_8 = 3'h3;
  localparam logic [2:0] BL_FULL = 3'h7;
  localparam logic [2:0] CL_2 = 3'h2;
  localparam logic [2:0] CL_3 = 3'h3;

  // timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int T_RP_NS = 20;
  localparam int T_RCD_NS = 20;
  localparam int T_RRD_NS = 15;
  localparam int T_RSC_NS = 15;
  localparam int T_RC_NS = 65;
  localparam int T_REF_NS = 64000000;
  localparam int REF_ROWS = 4096;
  localparam int T_RP_CYC = (T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_RCD_CYC = (T_RCD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_RRD_CYC = (T_RRD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_RSC_CYC = (T_RSC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_RC_CYC = (T_RC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REF_INTERVAL_CYC = T_REF_NS / (REF_ROWS * CLK_PERIOD_NS);

  // controller registers
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_WDATA = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_RDATA = 8'h0C;
  localparam logic [7:0] REG_CTRL = 8'h10;
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_BANK_LSB = 4;
  localparam int CMD_ADDR_LSB = 8;
  localparam int CMD_DQM_BIT = 20;
  localparam int CTRL_CKE_BIT = 0;
  localparam int CTRL_AREF_BIT = 1;
  localparam int CTRL_CL_LSB = 4;
  localparam logic [31:0] CTRL_RESET = 32'h00000023;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_RDVALID_BIT = 1;
  localparam int ST_REFPEND_BIT = 2;

  typedef enum logic [2:0] {
    ST_RUN = 3'b001,
    ST_PDOWN = 3'b010,
    ST_SREF = 3'b100
  } dev_state_t;

  typedef enum logic [1:0] {
    CS_IDLE = 2'b01,
    CS_WAIT = 2'b10
  } ctl_state_t;

  // low column bits that wrap inside one burst
  function automatic logic [COL_W-1:0] burstMask(input logic [2:0] code);
    case (code)
      BL_1: burstMask = 10'h000;
      BL_2: burstMask = 10'h001;
      BL_4: burstMask = 10'h003;
      BL_8: burstMask = 10'h007;
      default: burstMask = 10'h3FF;
    endcase
  endfunction

endpackage
